// File: pkg/cg_pkg.sv
package cg_pkg;

    // Bus and datapath widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W  = 8;
    localparam int SEL_W  = 3;
    localparam int PRE_W  = 8;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] TIMER_MODE_OFF   = 8'h00;
    localparam logic [ADDR_W-1:0] LOW_CMP_OFF      = 8'h04;
    localparam logic [ADDR_W-1:0] HIGH_CMP_OFF     = 8'h08;
    localparam logic [ADDR_W-1:0] CARRIER_CTRL_OFF = 8'h0C;
    localparam logic [ADDR_W-1:0] ENV_CTRL_OFF     = 8'h10;
    localparam logic [ADDR_W-1:0] ENV_CMP_OFF      = 8'h14;
    localparam logic [ADDR_W-1:0] STATUS_OFF       = 8'h18;

    // Field positions, timer_mode_control
    localparam int MODE_RUN_BIT = 7;
    localparam int MODE_SEL_LSB = 4;
    // Field positions, carrier_control
    localparam int CAR_RMC_BIT  = 2;
    localparam int CAR_GBUF_BIT = 1;
    localparam int CAR_GACT_BIT = 0;
    // Field positions, envelope_timer_control
    localparam int ENV_RUN_BIT  = 7;
    localparam int ENV_SEL_LSB  = 4;
    // Field positions, status word
    localparam int STAT_CNT_LSB   = 0;
    localparam int STAT_CAR_BIT   = 8;
    localparam int STAT_PHASE_BIT = 9;
    localparam int STAT_PEND_BIT  = 10;
    localparam int STAT_PIN_BIT   = 11;
    localparam int STAT_ENV_LSB   = 16;

    // Reset values
    localparam logic [CNT_W-1:0]  CMP_RST  = 8'h00;
    localparam logic [CNT_W-1:0]  CNT_RST  = 8'h00;
    localparam logic [SEL_W-1:0]  SEL_RST  = 3'h0;
    localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;

    // Count clocks a high-width write must age before it may be applied
    localparam logic [1:0] HIGH_XFER_CLKS = 2'h3;

    typedef enum logic {
        CG_LOW_PHASE,
        CG_HIGH_PHASE
    } cg_phase_e;

    // APB request from the master
    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } cg_apb_req_s;

    // Whole state of the carrier timer
    typedef struct packed {
        logic              count_run;
        logic [SEL_W-1:0]  count_clock_select;
        logic [CNT_W-1:0]  low_width_compare;
        logic [CNT_W-1:0]  high_width_compare;
        logic [CNT_W-1:0]  high_pend_val;
        logic              high_pend;
        logic [1:0]        high_age;
        logic              remote_output_enable;
        logic              carrier_gate_buffer;
        logic              carrier_gate_active;
        logic              envelope_count_run;
        logic [SEL_W-1:0]  env_clock_select;
        logic [CNT_W-1:0]  envelope_compare;
        logic [CNT_W-1:0]  env_count;
        logic              env_pend;
        logic [CNT_W-1:0]  count;
        cg_phase_e         phase;
        logic              carrier;
        logic              pass_en;
        logic              pin;
        logic              match_irq;
        logic              synced_evt;
        logic              env_irq;
        logic [DATA_W-1:0] prdata;
    } cg_state_s;

endpackage

// File: hw/cg_prescaler.sv
`timescale 1ns/1ps

// Count clock source: one tick every 2**sel system clocks
module cg_prescaler
    import cg_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             run,
    input  wire logic [SEL_W-1:0] sel,
    output logic                  tick
);

    logic [PRE_W-1:0] div;
    logic [PRE_W-1:0] next_div;
    logic [PRE_W-1:0] mask;

    // Held at zero while stopped so the first tick is a full period away
    always_comb begin
        mask     = PRE_W'((1 << sel) - 1);
        tick     = run && ((div & mask) == mask);
        next_div = run ? PRE_W'(div + 1'b1) : '0;
    end

    // Free divider register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            div <= '0;
        end else begin
            div <= next_div;
        end
    end

endmodule

// File: hw/cg_carrier_timer.sv
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ps

// What this block does
// - Low carrier phase timed by low compare, high phase by high compare.
// - Pin: gate 0 low; enable 0 gate 1 high; both 1 gives carrier.
// - Gate is buffer bit (read/write) plus active bit (read only).
// - Envelope irq synced to timer clock, copies buffer gate into active.
// - Run bit starts counter; carrier stays default until first match.
// - Low compare first; match raises irq, inverts carrier, clears, swaps.
// - High match raises irq, inverts carrier, clears, swaps back; repeats.
// - Period N+M+2 count clocks, high width M+1 count clocks.
// - High compare write applied at next old match, after three clocks.
// - Active gate 1 passes carrier from next carrier rising edge.
// - Active gate 0 during carrier high keeps pin high to phase end.
// - Envelope run bit starts the envelope counter pacing gate transfers.
// - Clearing run bit stops the carrier counter.
// - Stopping returns timer irq and output pin to default level.
// - High compare delay counted in selected count clock.
module cg_carrier_timer
    import cg_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire cg_apb_req_s       apb_req,
    output logic [DATA_W-1:0]      prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   timer_output_pin,
    output logic                   timer_match_irq,
    output logic                   synced_envelope_event,
    output logic                   envelope_counter_irq
);

    cg_state_s        s;
    cg_state_s        next_s;
    logic             timer_tick;
    logic             env_tick;
    logic             setup_phase;
    logic             access_phase;
    logic [CNT_W-1:0] active_cmp;
    logic [1:0]       aged;

    // Known register word at this byte address
    function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
        case (a)
            TIMER_MODE_OFF,
            LOW_CMP_OFF,
            HIGH_CMP_OFF,
            CARRIER_CTRL_OFF,
            ENV_CTRL_OFF,
            ENV_CMP_OFF,
            STATUS_OFF: addr_ok = 1'b1;
            default:    addr_ok = 1'b0;
        endcase
    endfunction

    // Read word for one register; unused bits read as zero
    function automatic logic [DATA_W-1:0] read_word(
        input logic [ADDR_W-1:0] a,
        input cg_state_s         st
    );
        logic [DATA_W-1:0] w;
        w = DATA_RST;
        case (a)
            TIMER_MODE_OFF: begin
                w[MODE_RUN_BIT]                   = st.count_run;
                w[MODE_SEL_LSB +: SEL_W]          = st.count_clock_select;
            end
            LOW_CMP_OFF: begin
                w[CNT_W-1:0] = st.low_width_compare;
            end
            HIGH_CMP_OFF: begin
                // Software sees the value it wrote, even before transfer
                w[CNT_W-1:0] = st.high_pend ? st.high_pend_val
                                            : st.high_width_compare;
            end
            CARRIER_CTRL_OFF: begin
                w[CAR_RMC_BIT]  = st.remote_output_enable;
                w[CAR_GBUF_BIT] = st.carrier_gate_buffer;
                w[CAR_GACT_BIT] = st.carrier_gate_active;
            end
            ENV_CTRL_OFF: begin
                w[ENV_RUN_BIT]          = st.envelope_count_run;
                w[ENV_SEL_LSB +: SEL_W] = st.env_clock_select;
            end
            ENV_CMP_OFF: begin
                w[CNT_W-1:0] = st.envelope_compare;
            end
            STATUS_OFF: begin
                w[STAT_CNT_LSB +: CNT_W] = st.count;
                w[STAT_CAR_BIT]          = st.carrier;
                w[STAT_PHASE_BIT]        = (st.phase == CG_HIGH_PHASE);
                w[STAT_PEND_BIT]         = st.high_pend;
                w[STAT_PIN_BIT]          = st.pin;
                w[STAT_ENV_LSB +: CNT_W] = st.env_count;
            end
            default: begin
                w = DATA_RST;
            end
        endcase
        read_word = w;
    endfunction

    // Count clock for the carrier timer
    cg_prescaler u_timer_pre (
        .clk   (clk),
        .reset (reset),
        .run   (s.count_run),
        .sel   (s.count_clock_select),
        .tick  (timer_tick)
    );

    // Count clock for the envelope counter
    cg_prescaler u_env_pre (
        .clk   (clk),
        .reset (reset),
        .run   (s.envelope_count_run),
        .sel   (s.env_clock_select),
        .tick  (env_tick)
    );

    // Bus phase decode
    assign setup_phase  = apb_req.psel && !apb_req.penable;
    assign access_phase = apb_req.psel && apb_req.penable;

    // Zero wait states; unknown addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = access_phase && !addr_ok(apb_req.paddr);

    // Compare register currently matched against the counter
    assign active_cmp = (s.phase == CG_LOW_PHASE) ? s.low_width_compare
                                                  : s.high_width_compare;

    // Age of a pending high-width write after this count clock
    assign aged = (s.high_age == HIGH_XFER_CLKS) ? s.high_age
                                                 : 2'(s.high_age + 2'h1);

    // Next state of the whole block
    always_comb begin
        next_s            = s;
        next_s.match_irq  = 1'b0;
        next_s.synced_evt = 1'b0;
        next_s.env_irq    = 1'b0;

        // Read data captured in setup, presented during access
        if (setup_phase && !apb_req.pwrite) begin
            next_s.prdata = read_word(apb_req.paddr, s);
        end

        if (!s.count_run) begin
            // Stopped: everything facing the pin back to default
            next_s.count     = CNT_RST;
            next_s.phase     = CG_LOW_PHASE;
            next_s.carrier   = 1'b0;
            next_s.pass_en   = 1'b0;
            next_s.pin       = 1'b0;
            next_s.high_pend = 1'b0;
            next_s.high_age  = 2'h0;
            next_s.env_pend  = 1'b0;
        end else begin
            if (timer_tick) begin
                // Envelope event resampled onto the count clock
                if (s.env_pend) begin
                    next_s.synced_evt          = 1'b1;
                    next_s.carrier_gate_active = s.carrier_gate_buffer;
                    next_s.env_pend            = 1'b0;
                end
                if (s.high_pend) begin
                    next_s.high_age = aged;
                end
                if (s.count == active_cmp) begin
                    // Match: both phases end the same way
                    next_s.count     = CNT_RST;
                    next_s.match_irq = 1'b1;
                    next_s.carrier   = !s.carrier;
                    if (s.phase == CG_LOW_PHASE) begin
                        next_s.phase = CG_HIGH_PHASE;
                    end else begin
                        next_s.phase = CG_LOW_PHASE;
                        // New width only after the old one has ended
                        if (s.high_pend && aged == HIGH_XFER_CLKS) begin
                            next_s.high_width_compare = s.high_pend_val;
                            next_s.high_pend          = 1'b0;
                        end
                    end
                end else begin
                    // Inclusive count gives N+1 and M+1 clocks per phase
                    next_s.count = CNT_W'(s.count + 1'b1);
                end
            end

            // Gate opens on a rising carrier edge, closes only when low
            if (next_s.carrier_gate_active && next_s.carrier
                && !s.carrier) begin
                next_s.pass_en = 1'b1;
            end else if (!next_s.carrier_gate_active && !next_s.carrier) begin
                next_s.pass_en = 1'b0;
            end

            // Output selection
            if (s.remote_output_enable) begin
                next_s.pin = next_s.pass_en && next_s.carrier;
            end else begin
                next_s.pin = next_s.carrier_gate_active;
            end
        end

        // Envelope counter paces the gate transfers
        if (!s.envelope_count_run) begin
            next_s.env_count = CNT_RST;
        end else if (env_tick) begin
            if (s.env_count == s.envelope_compare) begin
                next_s.env_count = CNT_RST;
                next_s.env_irq   = 1'b1;
            end else begin
                next_s.env_count = CNT_W'(s.env_count + 1'b1);
            end
        end

        // A new envelope event wins over its own consumption
        if (s.env_irq && s.count_run) begin
            next_s.env_pend = 1'b1;
        end

        // Register writes take effect in the access phase
        if (access_phase && apb_req.pwrite) begin
            case (apb_req.paddr)
                TIMER_MODE_OFF: begin
                    next_s.count_run =
                        apb_req.pwdata[MODE_RUN_BIT];
                    next_s.count_clock_select =
                        apb_req.pwdata[MODE_SEL_LSB +: SEL_W];
                end
                LOW_CMP_OFF: begin
                    // Rewriting while running is left to software
                    next_s.low_width_compare =
                        apb_req.pwdata[CNT_W-1:0];
                end
                HIGH_CMP_OFF: begin
                    if (s.count_run) begin
                        // Latched; a later write restarts the aging
                        next_s.high_pend_val =
                            apb_req.pwdata[CNT_W-1:0];
                        next_s.high_pend     = 1'b1;
                        next_s.high_age      = 2'h0;
                    end else begin
                        next_s.high_width_compare =
                            apb_req.pwdata[CNT_W-1:0];
                    end
                end
                CARRIER_CTRL_OFF: begin
                    next_s.remote_output_enable =
                        apb_req.pwdata[CAR_RMC_BIT];
                    next_s.carrier_gate_buffer =
                        apb_req.pwdata[CAR_GBUF_BIT];
                end
                ENV_CTRL_OFF: begin
                    next_s.envelope_count_run =
                        apb_req.pwdata[ENV_RUN_BIT];
                    next_s.env_clock_select =
                        apb_req.pwdata[ENV_SEL_LSB +: SEL_W];
                end
                ENV_CMP_OFF: begin
                    next_s.envelope_compare =
                        apb_req.pwdata[CNT_W-1:0];
                end
                default: begin
                    // Status and unknown words ignore writes
                    next_s.envelope_compare = next_s.envelope_compare;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s.count_run            <= 1'b0;
            s.count_clock_select   <= SEL_RST;
            s.low_width_compare    <= CMP_RST;
            s.high_width_compare   <= CMP_RST;
            s.high_pend_val        <= CMP_RST;
            s.high_pend            <= 1'b0;
            s.high_age             <= 2'h0;
            s.remote_output_enable <= 1'b0;
            s.carrier_gate_buffer  <= 1'b0;
            s.carrier_gate_active  <= 1'b0;
            s.envelope_count_run   <= 1'b0;
            s.env_clock_select     <= SEL_RST;
            s.envelope_compare     <= CMP_RST;
            s.env_count            <= CNT_RST;
            s.env_pend             <= 1'b0;
            s.count                <= CNT_RST;
            s.phase                <= CG_LOW_PHASE;
            s.carrier              <= 1'b0;
            s.pass_en              <= 1'b0;
            s.pin                  <= 1'b0;
            s.match_irq            <= 1'b0;
            s.synced_evt           <= 1'b0;
            s.env_irq              <= 1'b0;
            s.prdata               <= DATA_RST;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from the state register
    assign prdata                = s.prdata;
    assign timer_output_pin      = s.pin;
    assign timer_match_irq       = s.match_irq;
    assign synced_envelope_event = s.synced_evt;
    assign envelope_counter_irq  = s.env_irq;

endmodule

// File: test/cg_carrier_timer_sva.sv
`timescale 1ns/1ps

// Port checks; run and remote bits shadowed from APB writes
module cg_carrier_timer_sva
    import cg_pkg::*;
(
    input wire logic              clk,
    input wire logic              reset,
    input wire cg_apb_req_s       apb_req,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              timer_output_pin,
    input wire logic              timer_match_irq,
    input wire logic              synced_envelope_event,
    input wire logic              envelope_counter_irq
);
    localparam int SYNC_MAX = 128;
    logic run_q;
    logic rmc_q;
    logic acc;

    // Access phase of any transfer
    assign acc = apb_req.psel && apb_req.penable;

    // Shadows change at the same edge as the design's registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            run_q <= 1'b0;
            rmc_q <= 1'b0;
        end else if (acc && apb_req.pwrite) begin
            if (apb_req.paddr == TIMER_MODE_OFF)
                run_q <= apb_req.pwdata[MODE_RUN_BIT];
            if (apb_req.paddr == CARRIER_CTRL_OFF)
                rmc_q <= apb_req.pwdata[CAR_RMC_BIT];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    irq_pulse_a: assert property (
        timer_match_irq |=> !timer_match_irq)
        else $error("match pulse longer than one cycle");
    sync_pulse_a: assert property (
        synced_envelope_event |=> !synced_envelope_event)
        else $error("synced event longer than one cycle");
    stop_out_a: assert property (
        !run_q |=> !timer_output_pin && !timer_match_irq)
        else $error("pin or match pulse while stopped");
    start_quiet_a: assert property (
        $rose(run_q) && rmc_q |-> (!timer_output_pin && !timer_match_irq) [*2])
        else $error("carrier left default level too early");
    carrier_edge_a: assert property (
        run_q && rmc_q && $changed(timer_output_pin) |-> timer_match_irq)
        else $error("pin moved away from a carrier edge");
    gate_pin_a: assert property (
        run_q && !rmc_q && $changed(timer_output_pin) |-> synced_envelope_event)
        else $error("pin moved without a gate transfer");
    stop_sync_a: assert property (
        !run_q |=> !synced_envelope_event)
        else $error("gate transfer while stopped");
    env_sync_a: assert property (
        run_q && envelope_counter_irq |-> ##[0:SYNC_MAX] synced_envelope_event)
        else $error("envelope event never synced");
    unmapped_a: assert property (
        acc && apb_req.paddr > STATUS_OFF
        |-> pslverr && (apb_req.pwrite || prdata == '0))
        else $error("unmapped access not refused");
    mapped_a: assert property (
        acc && apb_req.paddr <= STATUS_OFF && apb_req.paddr[1:0] == 2'b00
        |-> pready && !pslverr)
        else $error("mapped access refused");

    cover property (synced_envelope_event);
    cover property (run_q && rmc_q && $rose(timer_output_pin));
    cover property (acc && pslverr);
endmodule

bind cg_carrier_timer cg_carrier_timer_sva u_sva (
    .clk                   (clk),
    .reset                 (reset),
    .apb_req               (apb_req),
    .prdata                (prdata),
    .pready                (pready),
    .pslverr               (pslverr),
    .timer_output_pin      (timer_output_pin),
    .timer_match_irq       (timer_match_irq),
    .synced_envelope_event (synced_envelope_event),
    .envelope_counter_irq  (envelope_counter_irq)
);

// File: test/cg_ir_stage.sv
`timescale 1ns/1ps

// Output stage model: times high width and period of the pin
module cg_ir_stage (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        pin,
    output logic             meas_valid,
    output logic [15:0]      high_w,
    output logic [15:0]      period
);
    logic        pin_d;
    logic        armed;
    logic [15:0] pcnt;
    logic [15:0] hcnt;

    // First rise only arms; a gap in the carrier gives one odd report
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pin_d      <= 1'b0;
            armed      <= 1'b0;
            pcnt       <= 16'h0000;
            hcnt       <= 16'h0000;
            meas_valid <= 1'b0;
            high_w     <= 16'h0000;
            period     <= 16'h0000;
        end else begin
            pin_d      <= pin;
            meas_valid <= 1'b0;
            if (pin && !pin_d) begin
                meas_valid <= armed;
                high_w     <= hcnt;
                period     <= pcnt;
                armed      <= 1'b1;
                pcnt       <= 16'h0001;
                hcnt       <= 16'h0001;
            end else begin
                pcnt <= pcnt + 16'h0001;
                hcnt <= hcnt + {15'h0000, pin};
            end
        end
    end
endmodule

// File: test/testbench.sv
`timescale 1ns/1ps

module testbench
    import cg_pkg::*;
;
    logic              clk;
    logic              reset;
    cg_apb_req_s       req;
    logic [DATA_W-1:0] prdata;
    logic              pready, pslverr, pin, mirq, sevt, eirq;
    logic              meas_valid;
    logic [15:0]       high_w, period;
    int                err_count, total_checks, seed;
    logic [32:0]       rq[$];
    logic [31:0]       mq[$];

    // 50 MHz system clock
    always #10 clk = ~clk;

    cg_carrier_timer u_cg_carrier_timer (
        .clk(clk), .reset(reset), .apb_req(req), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer_output_pin(pin),
        .timer_match_irq(mirq), .synced_envelope_event(sevt),
        .envelope_counter_irq(eirq));
    cg_ir_stage u_cg_ir_stage (
        .clk(clk), .reset(reset), .pin(pin), .meas_valid(meas_valid),
        .high_w(high_w), .period(period));

    task automatic chk(input string what, input logic [32:0] e,
                       input logic [32:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // One APB transfer; reads leave their expected {pslverr, data}
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [32:0] e);
        int n;
        // Start right after a rising edge, one idle cycle after the last
        @(posedge clk);
        if (!w)
            rq.push_back(e);
        req.psel <= 1'b1;
        req.pwrite <= w;
        req.paddr <= a;
        req.pwdata <= d;
        @(posedge clk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_count++;
            close_out();
        end
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    // Bounded wait until every pulse note has been matched
    task automatic drain();
        int n;
        n = 0;
        while (mq.size() > 0 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 3000) begin
            err_count++;
            close_out();
        end
    endtask

    // Read data are taken at the access edge
    always @(posedge clk) begin
        if (req.psel && req.penable && !req.pwrite && pready === 1'b1)
            chk("apb read", rq.pop_front(), {pslverr, prdata});
    end

    // Pulses from the output stage, compared only when a note waits
    always @(posedge clk) begin
        if (meas_valid === 1'b1 && mq.size() > 0)
            chk("pulse", {1'b0, mq.pop_front()}, {1'b0, high_w, period});
    end

    // Carrier at count clock 2**s, envelope three steps slower
    task automatic carrier(input int s);
        logic [7:0] n;
        logic [7:0] m;
        n = 8'(($random(seed) & 7) + 1);
        m = 8'(($random(seed) & 7) + 1);
        apb(1, LOW_CMP_OFF, {24'h00_0000, n}, '0);
        apb(1, HIGH_CMP_OFF, {24'h00_0000, m}, '0);
        apb(1, CARRIER_CTRL_OFF, 32'h0000_0006, '0);
        apb(1, ENV_CMP_OFF, 32'h0000_0003, '0);
        apb(1, TIMER_MODE_OFF, 32'h0000_0080 | 32'(s << 4), '0);
        apb(1, ENV_CTRL_OFF, 32'h0000_0080 | 32'((s + 3) << 4), '0);
        repeat (300) @(posedge clk);
        apb(0, CARRIER_CTRL_OFF, '0, 33'h0_0000_0007);
        mq.push_back({16'((m + 1) << s), 16'((n + m + 2) << s)});
        drain();
        m = 8'(($random(seed) & 7) + 1);
        apb(1, HIGH_CMP_OFF, {24'h00_0000, m}, '0);
        repeat (200) @(posedge clk);
        mq.push_back({16'((m + 1) << s), 16'((n + m + 2) << s)});
        drain();
        apb(1, CARRIER_CTRL_OFF, 32'h0000_0004, '0);
        repeat (300) @(posedge clk);
        apb(0, CARRIER_CTRL_OFF, '0, 33'h0_0000_0004);
        @(negedge clk);
        chk("gated pin", 33'h0_0000_0000, {32'h0000_0000, pin});
        apb(1, ENV_CTRL_OFF, 32'h0000_0000, '0);
        repeat (20) @(posedge clk);
        apb(1, TIMER_MODE_OFF, 32'h0000_0000, '0);
        // Pin settles one clock after the run bit falls
        repeat (2) @(negedge clk);
        chk("stopped pin", 33'h0_0000_0000, {32'h0000_0000, pin});
        $display("carrier test at select %0d done", s);
    endtask

    initial begin
        clk = 1'b0;
        reset = 1'b1;
        req = '0;
        seed = 60735;
        err_count = 0;
        total_checks = 0;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        // Reset values, refused address, read-only active gate
        apb(0, LOW_CMP_OFF, '0, 33'h0_0000_0000);
        apb(0, HIGH_CMP_OFF, '0, 33'h0_0000_0000);
        apb(0, CARRIER_CTRL_OFF, '0, 33'h0_0000_0000);
        apb(0, 8'h1C, '0, 33'h1_0000_0000);
        apb(1, 8'h1C, 32'h0000_0005, '0);
        apb(1, CARRIER_CTRL_OFF, 32'h0000_0007, '0);
        apb(0, CARRIER_CTRL_OFF, '0, 33'h0_0000_0006);
        $display("register test done");
        carrier(0);
        carrier(1);
        // Remote output off: pin follows the active gate
        apb(1, CARRIER_CTRL_OFF, 32'h0000_0002, '0);
        apb(1, HIGH_CMP_OFF, 32'h0000_0001, '0);
        apb(1, TIMER_MODE_OFF, 32'h0000_0080, '0);
        apb(1, ENV_CTRL_OFF, 32'h0000_00B0, '0);
        repeat (200) @(posedge clk);
        chk("level pin", 33'h0_0000_0001, {32'h0000_0000, pin});
        apb(1, CARRIER_CTRL_OFF, 32'h0000_0000, '0);
        repeat (200) @(posedge clk);
        chk("level pin", 33'h0_0000_0000, {32'h0000_0000, pin});
        // Reopen the gate so that stopping has a high pin to return
        apb(1, CARRIER_CTRL_OFF, 32'h0000_0002, '0);
        repeat (200) @(posedge clk);
        chk("level pin", 33'h0_0000_0001, {32'h0000_0000, pin});
        apb(1, ENV_CTRL_OFF, 32'h0000_0000, '0);
        repeat (20) @(posedge clk);
        apb(1, TIMER_MODE_OFF, 32'h0000_0000, '0);
        repeat (2) @(negedge clk);
        chk("stopped pin", 33'h0_0000_0000, {32'h0000_0000, pin});
        $display("level output test done");
        close_out();
    end
endmodule
